// [hdl/sct_regs.svh]
`ifndef SCT_REGS_SVH
`define SCT_REGS_SVH

// Register lengths
`define SCT_IR_W        5
`define SCT_ID_W        32
`define SCT_USR_W       96
`define SCT_SIG_W       21

// Field positions inside configuration A
`define SCT_SEC_BIT     95
`define SCT_SIG_LSB     74

// Instruction codes
`define SCT_I_EXTEST    5'h00
`define SCT_I_SELUSR    5'h01
`define SCT_I_ERASE_A   5'h02
`define SCT_I_ERASE_B   5'h03
`define SCT_I_VERIFY_A  5'h04
`define SCT_I_VERIFY_B  5'h05
`define SCT_I_PROG_A    5'h06
`define SCT_I_PROG_B    5'h07
`define SCT_I_ENCAL     5'h0C
`define SCT_I_IDCODE    5'h0D
`define SCT_I_SAMPLE    5'h1E
`define SCT_I_BYPASS    5'h1F

// Reset values
`define SCT_CFG_RST     96'h0
`define SCT_OP_RST      3'h0

`endif

// [hdl/sct_pkg.sv]
package sct_pkg;

   // Controller states
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } sct_state_t;

   // Nonvolatile operations
   typedef enum logic [2:0] {
      OP_NONE, OP_PROG_A, OP_PROG_B, OP_ERASE_A, OP_ERASE_B, OP_VER_A, OP_VER_B
   } sct_op_t;

   // Data register in the scan path
   typedef enum logic [1:0] {
      DR_BYPASS, DR_ID, DR_USER
   } sct_dr_t;

endpackage : sct_pkg

// [hdl/sct_top.sv]
`timescale 1ns/1ps
`include "sct_regs.svh"
module sct_top
   import sct_pkg::*;
#(
   parameter logic [31:0] ID_CODE = 32'h0A5A_5001 // Arbitrary value, bit 0 set
) (
   // System clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // Serial test port
   input  wire logic                  tck,
   input  wire logic                  tms,
   input  wire logic                  tdi,
   output logic                       tdo,
   output logic                       tdo_oe,
   // Stored configuration and busy flag
   output logic [`SCT_USR_W-1:0]      cfg_a,
   output logic [`SCT_USR_W-1:0]      cfg_b,
   output logic [`SCT_SIG_W-1:0]      user_signature_field,
   output logic                       readout_security_bit,
   output logic                       nvm_busy
);

   // Test-clock domain state
   sct_state_t              state_q;
   sct_state_t              state_d;
   logic [`SCT_IR_W-1:0]    ir_sr_q;
   logic [`SCT_IR_W-1:0]    ir_q;
   logic                    bypass_q;
   logic [`SCT_ID_W-1:0]    id_sr_q;
   logic [`SCT_USR_W-1:0]   usr_sr_q;
   sct_dr_t                 dr_sel;
   sct_op_t                 pend_q;
   sct_op_t                 launch_op;
   sct_op_t                 op_q;
   logic [`SCT_USR_W-1:0]   op_data_q;
   logic                    req_tgl_q;
   logic [2:0]              ack_sync_q;
   logic                    ack_lvl_q;
   logic                    tdo_q;
   logic                    tdo_oe_q;
   logic                    idle_entry;
   logic                    rdback_ok;
   logic                    launch_go;

   // System-clock domain state
   logic [2:0]              req_sync_q;
   logic                    ack_tgl_q;
   logic [`SCT_USR_W-1:0]   cfg_a_q;
   logic [`SCT_USR_W-1:0]   cfg_b_q;
   logic [`SCT_USR_W-1:0]   rdback_q;
   logic                    busy_q;
   logic                    req_lvl;

   // Test-clock domain logic

   always_comb begin
      state_d = state_q;
      case (state_q)
         TLR:     state_d = tms ? TLR    : RTI;
         RTI:     state_d = tms ? SEL_DR : RTI;
         SEL_DR:  state_d = tms ? SEL_IR : CAP_DR;
         CAP_DR:  state_d = tms ? EX1_DR : SH_DR;
         SH_DR:   state_d = tms ? EX1_DR : SH_DR;
         EX1_DR:  state_d = tms ? UPD_DR : PAU_DR;
         PAU_DR:  state_d = tms ? EX2_DR : PAU_DR;
         EX2_DR:  state_d = tms ? UPD_DR : SH_DR;
         UPD_DR:  state_d = tms ? SEL_DR : RTI;
         SEL_IR:  state_d = tms ? TLR    : CAP_IR;
         CAP_IR:  state_d = tms ? EX1_IR : SH_IR;
         SH_IR:   state_d = tms ? EX1_IR : SH_IR;
         EX1_IR:  state_d = tms ? UPD_IR : PAU_IR;
         PAU_IR:  state_d = tms ? EX2_IR : PAU_IR;
         EX2_IR:  state_d = tms ? UPD_IR : SH_IR;
         UPD_IR:  state_d = tms ? SEL_DR : RTI;
         default: state_d = TLR;
      endcase
   end

   always_ff @(posedge tck or posedge rst) begin
      if (rst) begin
         state_q <= TLR;
      end else begin
         state_q <= state_d;
      end
   end

   // all ones and all zeros select bypass
   always_comb begin
      case (ir_q)
         `SCT_I_IDCODE: dr_sel = DR_ID;
         `SCT_I_SELUSR: dr_sel = DR_USER;
         default:       dr_sel = DR_BYPASS;
      endcase
   end

   // Instruction shift path and active instruction
   always_ff @(posedge tck or posedge rst) begin
      if (rst) begin
         ir_sr_q <= `SCT_I_IDCODE;
         ir_q    <= `SCT_I_IDCODE;
      end else begin
         case (state_q)
            TLR: ir_q <= `SCT_I_IDCODE;
            CAP_IR: ir_sr_q <= `SCT_I_IDCODE;
            SH_IR: ir_sr_q <= {tdi, ir_sr_q[`SCT_IR_W-1:1]};
            UPD_IR: ir_q <= ir_sr_q;
            default: ir_q <= ir_q;
         endcase
      end
   end

   always_ff @(posedge tck or posedge rst) begin
      if (rst) begin
         bypass_q <= 1'b0;
      end else if (dr_sel == DR_BYPASS) begin
         if (state_q == CAP_DR) begin
            bypass_q <= 1'b0;
         end else if (state_q == SH_DR) begin
            bypass_q <= tdi;
         end
      end
   end

   always_ff @(posedge tck or posedge rst) begin
      if (rst) begin
         id_sr_q <= 32'h0000_0000;
      end else if (dr_sel == DR_ID) begin
         if (state_q == CAP_DR) begin
            id_sr_q <= ID_CODE;
         end else if (state_q == SH_DR) begin
            id_sr_q <= {tdi, id_sr_q[`SCT_ID_W-1:1]};
         end
      end
   end

   always_ff @(posedge tck or posedge rst) begin
      if (rst) begin
         usr_sr_q <= `SCT_CFG_RST;
      end else if (dr_sel == DR_USER) begin
         if (state_q == CAP_DR) begin
            // Zeros until the last operation has been acknowledged
            usr_sr_q <= rdback_ok ? rdback_q : `SCT_CFG_RST;
         end else if (state_q == SH_DR) begin
            usr_sr_q <= {tdi, usr_sr_q[`SCT_USR_W-1:1]};
         end
      end
   end

   // operation to launch, fresh from Update-IR or pending
   always_comb begin
      launch_op = pend_q;
      if (state_q == UPD_IR) begin
         case (ir_sr_q)
            `SCT_I_PROG_A:   launch_op = OP_PROG_A;
            `SCT_I_PROG_B:   launch_op = OP_PROG_B;
            `SCT_I_ERASE_A:  launch_op = OP_ERASE_A;
            `SCT_I_ERASE_B:  launch_op = OP_ERASE_B;
            `SCT_I_VERIFY_A: launch_op = OP_VER_A;
            `SCT_I_VERIFY_B: launch_op = OP_VER_B;
            default:         launch_op = OP_NONE;
         endcase
      end
   end

   // Entry into idle from a scan, not from reset
   assign idle_entry = (state_d == RTI) && (state_q != RTI) && (state_q != TLR);
   // Readback and a new launch wait for the last acknowledge
   assign rdback_ok  = (ack_lvl_q == req_tgl_q);
   assign launch_go  = idle_entry && (launch_op != OP_NONE) && rdback_ok;

   // idle with nothing pending does nothing
   always_ff @(posedge tck or posedge rst) begin
      if (rst) begin
         pend_q <= OP_NONE;
      end else if (state_q == TLR || idle_entry) begin
         // Reset or idle entry consumes what was pending
         pend_q <= OP_NONE;
      end else if (state_q == UPD_IR) begin
         pend_q <= launch_op;
      end
   end

   // shifted user data held for programming
   always_ff @(posedge tck or posedge rst) begin
      if (rst) begin
         op_q      <= OP_NONE;
         op_data_q <= `SCT_CFG_RST;
         req_tgl_q <= 1'b0;
      end else if (launch_go) begin
         op_q      <= launch_op;
         op_data_q <= usr_sr_q;
         req_tgl_q <= ~req_tgl_q;
      end
   end

   // Acknowledge toggle brought back from the system clock
   always_ff @(posedge tck or posedge rst) begin
      if (rst) begin
         ack_sync_q <= 3'h0;
         ack_lvl_q  <= 1'b0;
      end else begin
         ack_sync_q <= {ack_sync_q[1:0], ack_tgl_q};
         if (ack_sync_q[1] == ack_sync_q[2]) begin
            ack_lvl_q <= ack_sync_q[2];
         end
      end
   end

   always_ff @(negedge tck or posedge rst) begin
      if (rst) begin
         tdo_q    <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else begin
         tdo_oe_q <= (state_q == SH_IR) || (state_q == SH_DR);
         // Value read by the far side at the next rising edge
         if (state_q == SH_IR) begin
            tdo_q <= ir_sr_q[0];
         end else begin
            case (dr_sel)
               DR_ID:   tdo_q <= id_sr_q[0];
               DR_USER: tdo_q <= usr_sr_q[0];
               default: tdo_q <= bypass_q;
            endcase
         end
      end
   end

   // System-clock domain logic
   // Operation word and data hold still while the request toggle is outstanding

   // Request toggle synchroniser, second and third must agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_sync_q <= 3'h0;
      end else begin
         req_sync_q <= {req_sync_q[1:0], req_tgl_q};
      end
   end

   // One-cycle request once the second and third stages agree
   assign req_lvl = (req_sync_q[1] == req_sync_q[2]) && (req_sync_q[2] != ack_tgl_q);

   // program sets ones from shifted data
   // security cleared only by erasing A
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_a_q <= `SCT_CFG_RST;
         cfg_b_q <= `SCT_CFG_RST;
      end else if (req_lvl) begin
         // Program only moves bits from zero to one
         case (op_q)
            OP_PROG_A:  cfg_a_q <= cfg_a_q | op_data_q;
            OP_PROG_B:  cfg_b_q <= cfg_b_q | op_data_q;
            OP_ERASE_A: cfg_a_q <= `SCT_CFG_RST;
            OP_ERASE_B: cfg_b_q <= `SCT_CFG_RST;
            default:    cfg_a_q <= cfg_a_q;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdback_q <= `SCT_CFG_RST;
      end else if (req_lvl) begin
         // Any other operation clears a stale readback
         case (op_q)
            OP_VER_A: rdback_q <= cfg_a_q[`SCT_SEC_BIT] ? `SCT_CFG_RST : cfg_a_q;
            OP_VER_B: rdback_q <= cfg_a_q[`SCT_SEC_BIT] ? `SCT_CFG_RST : cfg_b_q;
            default:  rdback_q <= `SCT_CFG_RST;
         endcase
      end
   end

   // Acknowledge and busy flag
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_tgl_q <= 1'b0;
         busy_q    <= 1'b0;
      end else begin
         busy_q <= req_lvl;
         if (req_lvl) begin
            ack_tgl_q <= req_sync_q[2];
         end
      end
   end

   // Outputs from flip-flops
   assign tdo                  = tdo_q;
   assign tdo_oe               = tdo_oe_q;
   assign cfg_a                = cfg_a_q;
   assign cfg_b                = cfg_b_q;
   assign user_signature_field = cfg_a_q[`SCT_SIG_LSB +: `SCT_SIG_W];
   assign readout_security_bit = cfg_a_q[`SCT_SEC_BIT];
   assign nvm_busy             = busy_q;

endmodule : sct_top

// [verification/sct_props.sv]
`timescale 1ns/1ps
`include "sct_regs.svh"
module sct_props
   import sct_pkg::*;
#(
   parameter logic [31:0] ID_CODE = 32'h0
) (
   // Clocks and reset
   input wire logic                  clk,
   input wire logic                  rst,
   // Serial test port
   input wire logic                  tck,
   input wire logic                  tms,
   input wire logic                  tdi,
   input wire logic                  tdo,
   input wire logic                  tdo_oe,
   // Stored configuration and busy flag
   input wire logic [`SCT_USR_W-1:0] cfg_a,
   input wire logic [`SCT_USR_W-1:0] cfg_b,
   input wire logic [`SCT_SIG_W-1:0] user_signature_field,
   input wire logic                  readout_security_bit,
   input wire logic                  nvm_busy
);
   // Next state per state nibble, mode-select low and high
   localparam logic [63:0] NXT0 = 64'h1BDDBBA146644311;
   localparam logic [63:0] NXT1 = 64'h2FEFCC0287855920;
   logic [3:0] st_q;
   logic [4:0] irs_q, ir_q;
   logic       oe_q, byp;
   // Instructions that fall back to the one-stage path
   assign byp = ir_q inside {`SCT_I_EXTEST, `SCT_I_SAMPLE, `SCT_I_BYPASS};
   // Reference controller
   always_ff @(posedge tck or posedge rst) begin
      if (rst) st_q <= TLR;
      else st_q <= tms ? NXT1[st_q*4+:4] : NXT0[st_q*4+:4];
   end
   // Reference instruction
   always_ff @(posedge tck or posedge rst) begin
      if (rst) begin
         irs_q <= 5'h00;
         ir_q  <= `SCT_I_IDCODE;
      end else begin
         if (st_q == SH_IR) irs_q <= {tdi, irs_q[4:1]};
         ir_q <= (st_q == TLR) ? `SCT_I_IDCODE : (st_q == UPD_IR) ? irs_q : ir_q;
      end
   end
   // Expected enable, moved on the falling edge
   always_ff @(negedge tck or posedge rst) begin
      if (rst) oe_q <= 1'b0;
      else oe_q <= st_q inside {SH_DR, SH_IR};
   end
   property p_oe; @(posedge tck) disable iff (rst) tdo_oe == oe_q; endproperty
   a_oe: assert property (p_oe) else $error("tdo_oe wrong");
   property p_fall; @(posedge clk) disable iff (rst)
      tck && $past(tck) |-> $stable(tdo); endproperty
   a_fall: assert property (p_fall) else $error("tdo moved while tck high");
   property p_trst; @(posedge tck) disable iff (rst) tms [*5] |=> !tdo_oe; endproperty
   a_trst: assert property (p_trst) else $error("no reset after five");
   property p_byp; @(posedge tck) disable iff (rst)
      (st_q == SH_DR && byp) ##1 st_q == SH_DR |-> tdo == $past(tdi); endproperty
   a_byp: assert property (p_byp) else $error("bypass delay wrong");
   property p_id; @(posedge tck) disable iff (rst)
      st_q == CAP_DR && ir_q == `SCT_I_IDCODE ##1 st_q == SH_DR |-> tdo == ID_CODE[0];
   endproperty
   a_id: assert property (p_id) else $error("id first bit wrong");
   property p_pulse; @(posedge clk) disable iff (rst) nvm_busy |=> !nvm_busy; endproperty
   a_pulse: assert property (p_pulse) else $error("busy too long");
   property p_cfg; @(posedge clk) disable iff (rst) !$stable({cfg_a, cfg_b}) |->
      (nvm_busy || $past(nvm_busy) || $past(nvm_busy, 2)) or (##[1:2] nvm_busy); endproperty
   a_cfg: assert property (p_cfg) else $error("cfg changed without op");
   property p_sig; @(posedge clk) disable iff (rst) {readout_security_bit,
      user_signature_field} == cfg_a[`SCT_SEC_BIT:`SCT_SIG_LSB]; endproperty
   a_sig: assert property (p_sig) else $error("signature field wrong");
endmodule : sct_props

// [verification/sct_host.sv]
`timescale 1ns/1ps
module sct_host (
   // Serial test port, programmer side
   output logic     tck,
   output logic     tms,
   output logic     tdi,
   input wire logic tdo
);
   // Clock stands low between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // One cycle: drive after the fall, sample at the rise
   task automatic tick(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #16 tck = 1'b1;
      o = tdo;
      #16 tck = 1'b0;
   endtask : tick
   task automatic reset_tap();
      logic o;
      repeat (5) tick(1'b1, ~tdi, o);
      tick(1'b0, ~tdi, o);
   endtask : reset_tap
   // scan from idle, optional pause after bit pa
   task automatic scan(input logic ir, input int n, input int pa, input logic [95:0] din,
                       output logic [95:0] dout);
      logic o;
      dout = '0;
      tick(1'b1, ~tdi, o);
      if (ir) tick(1'b1, ~tdi, o);
      repeat (2) tick(1'b0, ~tdi, o);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1 || i == pa, din[i], o);
         dout[i] = o;
         if (i == pa) for (int j = 0; j < 4; j++) tick(j == 2, ~tdi, o);
      end
      tick(1'b1, ~tdi, o);
      tick(1'b0, ~tdi, o);
   endtask : scan
endmodule : sct_host

// [verification/tb.sv]
`timescale 1ns/1ps
`include "sct_regs.svh"
module tb;
   localparam logic [31:0] ID_T = 32'h0C3C_7001; // Arbitrary value, bit 0 set
   logic        clk, rst, tck, tms, tdi, tdo, tdo_oe, sec, busy;
   logic [95:0] cfg_a, cfg_b, ea, eb, d;
   logic [20:0] sig;
   int          err_total, checked, cyc, nb;
   sct_top #(.ID_CODE(ID_T)) i_dut (.clk, .rst, .tck, .tms, .tdi, .tdo, .tdo_oe, .cfg_a,
      .cfg_b, .user_signature_field(sig), .readout_security_bit(sec), .nvm_busy(busy));
   sct_host i_host (.tck, .tms, .tdi, .tdo);
   // System clock
   always #2 clk = ~clk;
   // Operation count and run ceiling
   always @(posedge clk) begin
      if (busy === 1'b1) nb++;
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         end_sim();
      end
   end
   task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic ir(input logic [4:0] c);
      logic [95:0] x;
      i_host.scan(1'b1, 5, -1, {91'h0, c}, x);
   endtask : ir
   // Load an instruction and wait a bounded time for its single operation
   task automatic op(input logic [4:0] c);
      int n0;
      n0 = nb;
      ir(c);
      for (int k = 0; k < 40 && nb == n0; k++) @(negedge clk);
      repeat (2) @(negedge clk);
      chk("op count", 96'(n0 + 1), 96'(nb));
   endtask : op
   task automatic t_id();
      i_host.scan(1'b0, 32, -1, '0, d);
      chk("id", 96'(ID_T), d);
      i_host.scan(1'b0, 32, 12, '0, d);
      chk("id paused", 96'(ID_T), d);
      $display("t_id done");
   endtask : t_id
   task automatic t_byp();
      logic [4:0] codes [3] = '{`SCT_I_EXTEST, `SCT_I_SAMPLE, `SCT_I_BYPASS};
      foreach (codes[i]) begin
         ir(codes[i]);
         i_host.scan(1'b0, 8, -1, 96'hA5, d);
         chk("bypass", 96'h4A, d);
      end
      i_host.reset_tap();
      i_host.scan(1'b0, 32, -1, '0, d);
      chk("id after reset", 96'(ID_T), d);
      $display("t_byp done");
   endtask : t_byp
   task automatic t_prog(input logic b, input logic [95:0] v);
      logic o;
      int   n0;
      ir(`SCT_I_SELUSR);
      i_host.scan(1'b0, 96, -1, v, d);
      op(`SCT_I_PROG_A + {4'h0, b});
      if (b) eb = eb | v;
      else ea = ea | v;
      chk("cfg_a", ea, cfg_a);
      chk("cfg_b", eb, cfg_b);
      chk("signature", 96'(ea[95:74]), 96'({sec, sig}));
      n0 = nb;
      repeat (8) i_host.tick(1'b0, ~tdi, o);
      chk("idle ops", 96'(n0), 96'(nb));
      op(`SCT_I_VERIFY_A + {4'h0, b});
      ir(`SCT_I_SELUSR);
      i_host.scan(1'b0, 96, -1, '0, d);
      chk("readback", ea[95] ? 96'h0 : (b ? eb : ea), d);
      $display("t_prog %0d done", b);
   endtask : t_prog
   task automatic t_erase();
      op(`SCT_I_VERIFY_B);
      ir(`SCT_I_SELUSR);
      i_host.scan(1'b0, 96, -1, '0, d);
      chk("secured b", ea[95] ? 96'h0 : eb, d);
      op(`SCT_I_ERASE_B);
      eb = 96'h0;
      chk("erased b", eb, cfg_b);
      chk("security kept", 96'(ea[95]), 96'(sec));
      op(`SCT_I_ERASE_A);
      ea = 96'h0;
      chk("erased a", ea, cfg_a);
      chk("security", 96'h0, 96'(sec));
      $display("t_erase done");
   endtask : t_erase
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   // Main sequence
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      ea  = '0;
      eb  = '0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      #5 i_host.reset_tap();
      t_id();
      t_byp();
      t_prog(1'b0, 96'h0123_4567_89AB_CDEF_0F1E_2D3C);
      t_prog(1'b1, 96'hFFFF_0000_A5A5_5A5A_1234_8765);
      t_prog(1'b0, 96'h8000_0000_0000_0000_0000_0001);
      t_erase();
      end_sim();
   end
endmodule : tb
bind sct_top sct_props #(.ID_CODE(ID_CODE)) i_props (.clk, .rst, .tck, .tms, .tdi, .tdo,
   .tdo_oe, .cfg_a, .cfg_b, .user_signature_field, .readout_security_bit, .nvm_busy);
